// >>> logic/pmp_cfg.svh
// Constants for the per-hart physical memory protection checker.
// Assumes a 32-bit APB register bus and a 34-bit physical address space.
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define PMP_REGIONS 8
`define PMP_AREG_W 32
`define PMP_PA_W 34
`define PMP_GRAIN_G 10
`define PMP_GRAIN_BYTES 4096
`define PMP_LINE_BYTES 64

// ****************************************************************
// Register offsets
// ****************************************************************
`define PMP_OFF_CFG_LO 12'h000
`define PMP_OFF_CFG_HI 12'h004
`define PMP_OFF_STATUS 12'h010
`define PMP_OFF_FADDR 12'h014
`define PMP_OFF_ADDR0 12'h020

// ****************************************************************
// Configuration field positions and reset values
// ****************************************************************
`define PMP_BIT_R 0
`define PMP_BIT_W 1
`define PMP_BIT_X 2
`define PMP_BIT_A_LO 3
`define PMP_BIT_A_HI 4
`define PMP_BIT_L 7
`define PMP_A_OFF 2'h0
`define PMP_A_TOR 2'h1
`define PMP_A_NA4 2'h2
`define PMP_A_NAPOT 2'h3
`define PMP_CFG_RESET 8'h00
`define PMP_ADDR_RESET 32'h0000_0000

`endif

// >>> logic/pmp_types_pkg.sv
// Types shared by the protection checker and its bench.
// Assumes pmp_cfg.svh is on the include path.
`default_nettype none
`include "pmp_cfg.svh"

package pmp_types_pkg;

    typedef enum logic [2:0] {
        KIND_FETCH = 3'h0,
        KIND_LOAD = 3'h1,
        KIND_STORE = 3'h2,
        KIND_FLUSH = 3'h3,
        KIND_DISCARD = 3'h4
    } access_kind_type;

    typedef enum logic [1:0] {
        PRIV_U = 2'h0,
        PRIV_S = 2'h1,
        PRIV_M = 2'h3
    } priv_type;

    typedef enum logic [2:0] {
        FAULT_NONE = 3'h0,
        FAULT_LOAD = 3'h1,
        FAULT_STORE = 3'h2,
        FAULT_FETCH = 3'h3,
        FAULT_BUS = 3'h4
    } fault_type;

    typedef struct packed {
        logic [`PMP_REGIONS-1:0][7:0] cfg;
        logic [`PMP_REGIONS-1:0][`PMP_AREG_W-1:0] addr;
        logic [31:0] prdata;
        logic resp_valid;
        logic resp_fault;
        logic resp_deny;
        fault_type resp_cause;
        logic resp_zero;
        logic resp_insn_exc;
        logic [`PMP_PA_W-1:0] resp_addr;
        logic insn_fail;
        fault_type last_cause;
        logic [`PMP_PA_W-1:0] last_addr;
    } state_type;

endpackage

`default_nettype wire

// >>> logic/pmp_checker.sv
// Per-hart physical memory protection checker with an APB register port.
// Assumes one instance per hart, one check request per cycle, and that the
// system address decoder flags reserved holes and reserved space.
//
// Operation
// - Only machine-mode (privileged) bus writes may change region registers.
// - Lowest-numbered matching region wins over higher-numbered ones.
// - Access succeeds only if the winning region covers every byte.
// - Machine access via unlocked fully matching region always allowed.
// - Locked regions and all S/U accesses use the R/W/X bits.
// - Denied load, store, fetch give load, store, fetch access faults.
// - Fetch fault reports the fetched target address, not the branch.
// - Any failing part of an instruction raises an exception for it.
// - Split stores may complete passing parts while another part faults.
// - Page-table walk accesses are checked as supervisor accesses.
// - Speculative checks never trap; they only report a deny.
// - Checks use current settings every cycle; no fence needed.
// - Settings apply only to this hart's own accesses.
// - External front-port master accesses are never checked.
// - Unmatched non-reserved access: S/U fail, machine allowed.
// - Unprotected reserved hole in a device reads zero, write dropped.
// - Unprotected reserved space outside devices gives a bus error.
// - Flush touching a locked region faults as store; else succeeds.
// - Discard invalidates without write-back, so never faults.
// - High background region under specific low regions is supported.
// - Eight regions with a 4096-byte smallest granule.
// - Eight-bit field holds R, W, X, two-bit mode and lock.
// - Locked region ignores config and address writes until reset.
// - Reset clears every mode and lock, leaving regions disabled.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pmp_cfg.svh"
`default_nettype none

module pmp_checker #(
    parameter int LINE_BYTES = `PMP_LINE_BYTES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chk_valid,
    input wire logic [`PMP_PA_W-1:0] chk_addr,
    input wire logic [3:0] chk_size,
    input wire logic [2:0] chk_kind,
    input wire logic [1:0] chk_priv,
    input wire logic chk_ptw,
    input wire logic chk_spec,
    input wire logic chk_ext,
    input wire logic chk_last,
    input wire logic map_hole,
    input wire logic map_reserved,
    output logic resp_valid,
    output logic resp_fault,
    output logic resp_deny,
    output logic [2:0] resp_cause,
    output logic resp_zero,
    output logic resp_insn_exc,
    output logic [`PMP_PA_W-1:0] resp_addr
);

    localparam int N = `PMP_REGIONS;
    localparam int EW = `PMP_PA_W + 2;

    pmp_types_pkg::state_type st_r;
    pmp_types_pkg::state_type st_nxt;

    // ****************************************************************
    // Region decode
    // ****************************************************************
    logic [EW-1:0] acc_lo;
    logic [EW-1:0] acc_hi;
    logic [N-1:0] ovl;
    logic [N-1:0] full;
    logic [N-1:0] lock_ovl;
    logic [EW-1:0] reg_lo [N];
    logic [EW-1:0] reg_hi [N];

    always_comb begin
        if (pmp_types_pkg::access_kind_type'(chk_kind) == pmp_types_pkg::KIND_FLUSH) begin
            acc_lo = {2'b00, chk_addr} & ~EW'(LINE_BYTES - 1);
            acc_hi = acc_lo + EW'(LINE_BYTES);
        end else begin
            acc_lo = {2'b00, chk_addr};
            acc_hi = acc_lo + EW'(chk_size);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_region
            logic [`PMP_AREG_W-1:0] t;
            logic [`PMP_AREG_W-1:0] ones;
            logic [1:0] mode;
            logic en;
            assign t = st_r.addr[gi] | `PMP_AREG_W'((1 << (`PMP_GRAIN_G - 1)) - 1);
            assign ones = t ^ (t + `PMP_AREG_W'(1));
            assign mode = st_r.cfg[gi][`PMP_BIT_A_HI:`PMP_BIT_A_LO];
            assign en = (mode == `PMP_A_TOR) || (mode == `PMP_A_NAPOT);
            always_comb begin
                if (mode == `PMP_A_TOR) begin
                    reg_hi[gi] = {2'b00, st_r.addr[gi] >> `PMP_GRAIN_G << `PMP_GRAIN_G, 2'b00};
                    if (gi == 0) begin
                        reg_lo[gi] = '0;
                    end else begin
                        reg_lo[gi] = {2'b00, st_r.addr[(gi == 0) ? 0 : gi - 1]
                            >> `PMP_GRAIN_G << `PMP_GRAIN_G, 2'b00};
                    end
                end else begin
                    reg_lo[gi] = {2'b00, t & ~ones, 2'b00};
                    reg_hi[gi] = reg_lo[gi] + {2'b00, ones, 2'b00} + EW'(4);
                end
            end
            assign ovl[gi] = en && (acc_lo < reg_hi[gi]) && (acc_hi > reg_lo[gi]);
            assign full[gi] = en && (acc_lo >= reg_lo[gi]) && (acc_hi <= reg_hi[gi]);
            assign lock_ovl[gi] = ovl[gi] && st_r.cfg[gi][`PMP_BIT_L];
        end
    endgenerate

    // ****************************************************************
    // Access decision
    // ****************************************************************
    logic hit;
    logic [2:0] hit_idx;
    logic [7:0] hcfg;
    logic perm;
    logic allow;
    logic bus_err;
    logic zero_rd;
    pmp_types_pkg::priv_type eff_priv;
    pmp_types_pkg::access_kind_type kind;
    pmp_types_pkg::fault_type cause;

    always_comb begin
        hit = 1'b0;
        hit_idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (ovl[i]) begin
                hit = 1'b1;
                hit_idx = 3'(i);
            end
        end
    end

    assign eff_priv = chk_ptw ? pmp_types_pkg::PRIV_S : pmp_types_pkg::priv_type'(chk_priv);
    assign kind = pmp_types_pkg::access_kind_type'(chk_kind);
    assign hcfg = st_r.cfg[hit_idx];

    always_comb begin
        case (kind)
            pmp_types_pkg::KIND_FETCH: perm = hcfg[`PMP_BIT_X];
            pmp_types_pkg::KIND_LOAD: perm = hcfg[`PMP_BIT_R];
            default: perm = hcfg[`PMP_BIT_W];
        endcase
    end

    always_comb begin
        allow = 1'b1;
        bus_err = 1'b0;
        zero_rd = 1'b0;
        if (chk_ext) begin
            allow = 1'b1;
        end else if (kind == pmp_types_pkg::KIND_DISCARD) begin
            allow = 1'b1;
        end else if (kind == pmp_types_pkg::KIND_FLUSH) begin
            allow = ~|lock_ovl;
        end else if (hit) begin
            if (!full[hit_idx]) begin
                allow = 1'b0;
            end else if (eff_priv == pmp_types_pkg::PRIV_M && !hcfg[`PMP_BIT_L]) begin
                allow = 1'b1;
            end else begin
                allow = perm;
            end
        end else if (map_reserved) begin
            bus_err = 1'b1;
            allow = 1'b0;
        end else if (map_hole) begin
            zero_rd = 1'b1;
        end else begin
            allow = (eff_priv == pmp_types_pkg::PRIV_M);
        end
    end

    always_comb begin
        if (bus_err) begin
            cause = pmp_types_pkg::FAULT_BUS;
        end else if (allow) begin
            cause = pmp_types_pkg::FAULT_NONE;
        end else if (kind == pmp_types_pkg::KIND_FETCH) begin
            cause = pmp_types_pkg::FAULT_FETCH;
        end else if (kind == pmp_types_pkg::KIND_LOAD) begin
            cause = pmp_types_pkg::FAULT_LOAD;
        end else begin
            cause = pmp_types_pkg::FAULT_STORE;
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic acc_phase;
    logic is_cfg;
    logic is_addr;
    logic mapped;
    logic [2:0] widx;
    logic [31:0] rd_val;

    assign acc_phase = psel && penable;
    assign is_cfg = (paddr == `PMP_OFF_CFG_LO) || (paddr == `PMP_OFF_CFG_HI);
    assign is_addr = (paddr[11:5] == 7'(`PMP_OFF_ADDR0 >> 5)) && (paddr[1:0] == 2'b00);
    assign widx = paddr[4:2];
    assign mapped = is_cfg || is_addr || (paddr == `PMP_OFF_STATUS)
        || (paddr == `PMP_OFF_FADDR);
    assign pready = 1'b1;
    assign pslverr = acc_phase && (!mapped || !pprot[0]);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (paddr == `PMP_OFF_CFG_LO) begin
            rd_val = st_r.cfg[3:0];
        end else if (paddr == `PMP_OFF_CFG_HI) begin
            rd_val = st_r.cfg[7:4];
        end else if (is_addr) begin
            rd_val = st_r.addr[widx];
        end else if (paddr == `PMP_OFF_STATUS) begin
            rd_val = {28'h000_0000, st_r.insn_fail, st_r.last_cause};
        end else if (paddr == `PMP_OFF_FADDR) begin
            rd_val = st_r.last_addr[`PMP_PA_W-1:2];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic wr_ok;
    logic fail_now;
    logic [7:0] wfield;

    assign wr_ok = acc_phase && pwrite && mapped && pprot[0];
    assign fail_now = !chk_spec && (cause != pmp_types_pkg::FAULT_NONE);

    always_comb begin
        st_nxt = st_r;
        wfield = 8'h00;
        if (psel && !penable) begin
            st_nxt.prdata = pprot[0] ? rd_val : 32'h0000_0000;
        end
        if (wr_ok && is_cfg) begin
            for (int b = 0; b < 4; b++) begin
                wfield = pwdata[8*b +: 8];
                // Write-only regions do not exist; W is dropped without R.
                wfield[`PMP_BIT_W] = wfield[`PMP_BIT_W] & wfield[`PMP_BIT_R];
                if (pstrb[b] && !st_r.cfg[{paddr[2], 2'(b)}][`PMP_BIT_L]) begin
                    st_nxt.cfg[{paddr[2], 2'(b)}] = wfield;
                end
            end
        end
        if (wr_ok && is_addr && !st_r.cfg[widx][`PMP_BIT_L]) begin
            if (!(widx != 3'h7 && st_r.cfg[widx + 3'h1][`PMP_BIT_L]
                && st_r.cfg[widx + 3'h1][`PMP_BIT_A_HI:`PMP_BIT_A_LO] == `PMP_A_TOR)) begin
                st_nxt.addr[widx] = pwdata;
            end
        end
        st_nxt.resp_valid = chk_valid;
        st_nxt.resp_fault = chk_valid && fail_now;
        st_nxt.resp_deny = chk_valid && !allow;
        st_nxt.resp_cause = chk_valid ? cause : pmp_types_pkg::FAULT_NONE;
        st_nxt.resp_zero = chk_valid && zero_rd;
        st_nxt.resp_insn_exc = 1'b0;
        if (chk_valid && fail_now) begin
            st_nxt.last_cause = cause;
            st_nxt.last_addr = chk_addr;
        end
        if (chk_valid) begin
            st_nxt.resp_addr = chk_addr;
            st_nxt.insn_fail = chk_last ? 1'b0 : (st_r.insn_fail || fail_now);
            st_nxt.resp_insn_exc = chk_last && (st_r.insn_fail || fail_now);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign resp_valid = st_r.resp_valid;
    assign resp_fault = st_r.resp_fault;
    assign resp_deny = st_r.resp_deny;
    assign resp_cause = st_r.resp_cause;
    assign resp_zero = st_r.resp_zero;
    assign resp_insn_exc = st_r.resp_insn_exc;
    assign resp_addr = st_r.resp_addr;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_user_wr_blocked;
        @(posedge pclk) disable iff (!presetn)
        (acc_phase && pwrite && !pprot[0]) |=> ($stable(st_r.cfg) && $stable(st_r.addr));
    endproperty
    a_user_wr_blocked: assert property (p_user_wr_blocked) else $error("unprivileged write changed");

    property p_lock_hold;
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && is_addr && st_r.cfg[widx][`PMP_BIT_L]) |=> $stable(st_r.addr);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked address was written");

    property p_partial_fails;
        @(posedge pclk) disable iff (!presetn)
        (chk_valid && !chk_ext && !chk_spec && kind == pmp_types_pkg::KIND_LOAD
            && hit && !full[hit_idx]) |=> (resp_fault && resp_cause == 3'h1);
    endproperty
    a_partial_fails: assert property (p_partial_fails) else $error("partial cover passed");

    property p_ext_free;
        @(posedge pclk) disable iff (!presetn)
        (chk_valid && chk_ext) |=> (resp_valid && !resp_deny);
    endproperty
    a_ext_free: assert property (p_ext_free) else $error("front port access denied");

    property p_spec_quiet;
        @(posedge pclk) disable iff (!presetn)
        (chk_valid && chk_spec) |=> !resp_fault;
    endproperty
    a_spec_quiet: assert property (p_spec_quiet) else $error("speculative check trapped");

    property p_discard_ok;
        @(posedge pclk) disable iff (!presetn)
        (chk_valid && kind == pmp_types_pkg::KIND_DISCARD) |=> !resp_deny;
    endproperty
    a_discard_ok: assert property (p_discard_ok) else $error("discard faulted");

    property p_default_su;
        @(posedge pclk) disable iff (!presetn)
        (chk_valid && !chk_ext && !chk_spec && !hit && !map_hole && !map_reserved
            && kind == pmp_types_pkg::KIND_STORE && eff_priv != pmp_types_pkg::PRIV_M)
            |=> (resp_fault && resp_cause == 3'h2);
    endproperty
    a_default_su: assert property (p_default_su) else $error("unmatched S/U store passed");

    property p_flush_lock;
        @(posedge pclk) disable iff (!presetn)
        (chk_valid && !chk_ext && !chk_spec && kind == pmp_types_pkg::KIND_FLUSH
            && |lock_ovl) |=> (resp_fault && resp_cause == 3'h2);
    endproperty
    a_flush_lock: assert property (p_flush_lock) else $error("flush on locked line passed");

    property p_insn_exc;
        @(posedge pclk) disable iff (!presetn)
        (chk_valid && !chk_last && fail_now) ##1 !(chk_valid && chk_last)
            ##1 (chk_valid && chk_last) |=> resp_insn_exc;
    endproperty
    a_insn_exc: assert property (p_insn_exc) else $error("instruction exception lost");

endmodule

`default_nettype wire

// >>> bench/hart_model.sv
// Hart side model: issues fetch, load/store, walk and cache requests.
// Assumes one request per call and the checker answering one cycle later.
`timescale 1ns/1ps
`include "pmp_cfg.svh"
`default_nettype none

module hart_model (
    input wire logic pclk,
    output logic chk_valid,
    output logic [`PMP_PA_W-1:0] chk_addr,
    output logic [3:0] chk_size,
    output logic [2:0] chk_kind,
    output logic [1:0] chk_priv,
    output logic chk_ptw,
    output logic chk_spec,
    output logic chk_ext,
    output logic chk_last,
    output logic map_hole,
    output logic map_reserved
);
    initial begin
        chk_valid = 1'b0;
        chk_addr = '0;
        chk_size = 4'h4;
        chk_kind = 3'h1;
        chk_priv = 2'h3;
        {chk_ptw, chk_spec, chk_ext, chk_last, map_hole, map_reserved} = 6'h00;
    end

    // ****************************************************************
    // Request
    // ****************************************************************
    // Flags are ptw, spec, ext, last, hole, reserved from the top bit down.
    task automatic req(input logic [`PMP_PA_W-1:0] a, input logic [3:0] sz,
                       input logic [2:0] k, input logic [1:0] p, input logic [5:0] fl);
        @(posedge pclk);
        chk_valid <= 1'b1;
        chk_addr <= a;
        chk_size <= sz;
        chk_kind <= k;
        chk_priv <= p;
        {chk_ptw, chk_spec, chk_ext, chk_last, map_hole, map_reserved} <= fl;
        @(posedge pclk);
        // Released address shows a changed value so no stale match can pass.
        chk_valid <= 1'b0;
        chk_addr <= ~a;
        #1;
    endtask
endmodule

`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the protection checker.
// Assumes the hart model drives check requests and APB is driven here.
`timescale 1ns/1ps
`include "pmp_cfg.svh"
`default_nettype none

`define CHK(n, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
    end \
end

module tb;
    localparam logic [2:0] EX = pmp_types_pkg::KIND_FETCH;
    localparam logic [2:0] LD = pmp_types_pkg::KIND_LOAD;
    localparam logic [2:0] ST = pmp_types_pkg::KIND_STORE;
    localparam logic [2:0] FL = pmp_types_pkg::KIND_FLUSH;
    localparam logic [2:0] DI = pmp_types_pkg::KIND_DISCARD;
    localparam logic [1:0] PU = pmp_types_pkg::PRIV_U;
    localparam logic [1:0] PS = pmp_types_pkg::PRIV_S;
    localparam logic [1:0] PM = pmp_types_pkg::PRIV_M;
    localparam logic [5:0] MID = 6'h00, LAST = 6'h04, PTW = 6'h24, SPEC = 6'h14;
    localparam logic [5:0] EXT = 6'h0c, HOLE = 6'h06, RES = 6'h05;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] pprot = 3'h1;
    logic [31:0] prdata;
    logic pready, pslverr, chk_valid, chk_ptw, chk_spec, chk_ext, chk_last;
    logic map_hole, map_reserved, resp_valid, resp_fault, resp_deny, resp_zero;
    logic resp_insn_exc;
    logic [`PMP_PA_W-1:0] chk_addr, resp_addr;
    logic [3:0] chk_size;
    logic [2:0] chk_kind, resp_cause;
    logic [1:0] chk_priv;
    int bad_count = 0, comparisons = 0, cyc = 0;

    pmp_checker u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pprot, .prdata, .pready, .pslverr, .chk_valid, .chk_addr, .chk_size,
        .chk_kind, .chk_priv, .chk_ptw, .chk_spec, .chk_ext, .chk_last, .map_hole,
        .map_reserved, .resp_valid, .resp_fault, .resp_deny, .resp_cause, .resp_zero,
        .resp_insn_exc, .resp_addr);
    hart_model u_hart (.pclk, .chk_valid, .chk_addr, .chk_size, .chk_kind, .chk_priv,
        .chk_ptw, .chk_spec, .chk_ext, .chk_last, .map_hole, .map_reserved);

    initial begin
        forever #25 pclk = ~pclk;
    end

    // Whole run needs about 130 cycles; the ceiling of 5000 leaves wide margin.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic give_verdict;
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [2:0] p, output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= p;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        acc(1'b1, a, d, 3'h1, rd, er);
        `CHK("wr_err", 1'b0, er)
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic er;
        acc(1'b0, a, 32'h0000_0000, 3'h1, rd, er);
        `CHK("prdata", e, rd)
        `CHK("pslverr", 1'b0, er)
    endtask

    // Expected vector is fault, deny, cause, zero from the top bit down.
    task automatic chk(input logic [`PMP_PA_W-1:0] a, input logic [3:0] sz,
                       input logic [2:0] k, input logic [1:0] p, input logic [5:0] fl,
                       input logic [5:0] e, input logic [5:0] m = 6'h3f);
        u_hart.req(a, sz, k, p, fl);
        `CHK("resp_valid", 1'b1, resp_valid)
        `CHK("resp", e, {resp_fault, resp_deny, resp_cause, resp_zero} & m)
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        logic [31:0] d;
        logic e;
        rdc(12'h000, 32'h0000_0000);
        rdc(12'h004, 32'h0000_0000);
        rdc(12'h020, 32'h0000_0000);
        acc(1'b0, 12'h040, 32'h0000_0000, 3'h1, d, e);
        `CHK("unmapped_err", 1'b1, e)
        acc(1'b1, 12'h020, 32'h0000_1234, 3'h0, d, e);
        `CHK("unpriv_err", 1'b1, e)
        rdc(12'h020, 32'h0000_0000);
    endtask

    task automatic t_default;
        chk(34'h0_0001_0000, 4'h4, LD, PM, LAST, 6'h00);
        chk(34'h0_0001_0000, 4'h4, LD, PS, LAST, 6'h32);
        chk(34'h0_0001_0000, 4'h4, ST, PU, LAST, 6'h34);
        chk(34'h0_0001_0000, 4'h4, EX, PU, LAST, 6'h36);
        chk(34'h0_0001_0000, 4'h4, ST, PU, EXT, 6'h00);
        chk(34'h0_0001_0000, 4'h4, LD, PM, HOLE, 6'h01);
        chk(34'h0_0001_0000, 4'h4, LD, PM, RES, 6'h38);
    endtask

    // Base registers go in before the packed config; unused fields stay zero.
    task automatic t_regions;
        wr(12'h020, 32'h0000_1fff);
        wr(12'h03c, 32'hffff_ffff);
        wr(12'h000, 32'h0000_0019);
        wr(12'h004, 32'h0f00_0000);
        // no paging here, so no fence.
        rdc(12'h000, 32'h0000_0019);
        chk(34'h0_0000_0100, 4'h4, ST, PS, LAST, 6'h34);
        chk(34'h0_0000_0100, 4'h4, LD, PS, LAST, 6'h00);
        chk(34'h0_0002_0000, 4'h4, ST, PS, LAST, 6'h00);
        chk(34'h0_0000_0100, 4'h4, ST, PM, LAST, 6'h00);
        chk(34'h0_0000_fffc, 4'h8, LD, PS, LAST, 6'h32);
        chk(34'h0_0000_0100, 4'h4, ST, PM, PTW, 6'h34);
        chk(34'h0_0000_0100, 4'h4, EX, PS, SPEC, 6'h10, 6'h30);
        chk(34'h0_0000_0100, 4'h4, EX, PS, LAST, 6'h36);
        `CHK("fetch_addr", 34'h0_0000_0100, resp_addr)
        rdc(12'h010, 32'h0000_0003);
        rdc(12'h014, 32'h0000_0040);
        chk(34'h0_0002_0000, 4'h4, ST, PS, MID, 6'h00);
        chk(34'h0_0000_0100, 4'h4, ST, PS, MID, 6'h34);
        chk(34'h0_0002_0008, 4'h4, ST, PS, LAST, 6'h00);
        `CHK("insn_exc", 1'b1, resp_insn_exc)
        chk(34'h0_0002_0008, 4'h4, ST, PS, LAST, 6'h00);
        `CHK("insn_exc", 1'b0, resp_insn_exc)
    endtask

    task automatic t_lock;
        wr(12'h000, 32'h0000_0099);
        wr(12'h020, 32'h0000_0000);
        wr(12'h000, 32'h0000_0000);
        rdc(12'h020, 32'h0000_1fff);
        rdc(12'h000, 32'h0000_0099);
        chk(34'h0_0000_0100, 4'h4, ST, PM, LAST, 6'h34);
        chk(34'h0_0000_0100, 4'h4, LD, PM, LAST, 6'h00);
        chk(34'h0_0000_0040, 4'h4, FL, PM, LAST, 6'h34);
        chk(34'h0_0002_0000, 4'h4, FL, PS, LAST, 6'h00);
        chk(34'h0_0000_0040, 4'h4, DI, PM, LAST, 6'h00);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h000, 32'h0000_0000);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_default();
        t_regions();
        t_lock();
        give_verdict();
    end
endmodule

`default_nettype wire
